// >>> rtl/rpoh_pkg.sv
// Package: register map, field positions and timing of the path overhead block.
package rpoh_pkg;

  // Register offsets on the 8-bit host address.
  localparam logic [7:0] ADDR_ALARM_STATUS = 8'h30;
  localparam logic [7:0] ADDR_IRQ_FLAGS    = 8'h31;
  localparam logic [7:0] ADDR_IRQ_ENABLES  = 8'h33;
  localparam logic [7:0] ADDR_LABEL        = 8'h37;
  localparam logic [7:0] ADDR_COUNT_LOW    = 8'h38;
  localparam logic [7:0] ADDR_COUNT_HIGH   = 8'h39;
  localparam logic [7:0] ADDR_GLOBAL       = 8'h00;

  // Bit positions shared by flag, enable and alarm registers.
  localparam int BIT_LABEL     = 7;
  localparam int BIT_POINTER   = 5;
  localparam int BIT_ALARM_IND = 3;
  localparam int BIT_REMOTE    = 2;
  localparam int BIT_PARITY    = 1;
  localparam int BIT_BLOCK     = 0;

  // Bits that exist in the flag and enable registers.
  localparam logic [7:0] IRQ_BITS_MASK = 8'haf;
  localparam logic [7:0] ENABLE_RESET  = 8'h00;

  // Expected signal label and number of mismatches that counts as a change.
  localparam logic [7:0] LABEL_EXPECTED  = 8'h13;
  localparam logic [1:0] LABEL_MISMATCHES = 2'h3;

  // Snapshot delay after a trigger write.
  localparam int CLK_PERIOD_PS    = 25000;
  localparam int SNAP_DELAY_PS    = 1000000;
  localparam int SNAP_DELAY_CYCLES =
    (SNAP_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SNAP_CNT_W = 6;

  // Host register port.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } host_req_t;

  // Received path overhead indications.
  typedef struct packed {
    logic       pointer_loss_state;
    logic       path_alarm_indication_state;
    logic       remote_defect_state;
    logic       parity_error;
    logic       block_error;
    logic       label_valid;
    logic [7:0] label;
  } path_ind_t;

  // Complete state of the block.
  typedef struct packed {
    logic [7:0]            flags;
    logic [7:0]            enables;
    logic [7:0]            signal_label_byte;
    logic [1:0]            mismatch_run;
    logic [15:0]           parity_error_count;
    logic [15:0]           snapshot;
    logic                  snap_busy;
    logic [SNAP_CNT_W-1:0] snap_timer;
    logic                  prev_pointer;
    logic                  prev_alarm;
    logic                  prev_remote;
    logic [7:0]            rdata;
    logic                  interrupt_out_n;
  } state_t;

endpackage

// >>> rtl/rx_path_overhead_status_regs.sv
// Receive path overhead status, interrupt and parity counter registers.
// Operation
// R1 - Remote defect alarm bit reads 1 while far-end receive failure is seen.
// R2 - Alarm status register shows pointer loss at bit 5, AIS at bit 3.
// R3 - Reading the flag register at 31H clears every flag in it; an event arriving in the read cycle stays set.
// R4 - Bit 7 flags a signal label change since the last flag read.
// R5 - Bit 5 flags a pointer loss state change either way.
// R6 - Bit 3 flags a path alarm indication state change.
// R7 - Bit 2 flags a remote defect state change.
// R8 - Bit 1 flags at least one path parity error.
// R9 - Bit 0 flags at least one far-end block error.
// R10 - Each flag drives the low interrupt only if enabled; enables reset 0.
// R11 - Label interrupt needs more than two consecutive labels differing 13H.
// R12 - Block error enable lets a detected block error raise the interrupt.
// R13 - Label register holds 13H or the first differing received label.
// R14 - About 1 us after writing 38H, 39H or 00H, snapshot and clear counter.
// R15 - Snapshot low byte at 38H, high byte at 39H, errors since last clear.
// R16 - Host waits 1 us before reading snapshot; reads status to clear flags.
`timescale 1ns/10ps
module rx_path_overhead_status_regs
  import rpoh_pkg::*;
#(
  parameter int SNAP_DELAY = SNAP_DELAY_CYCLES
) (
  // Clock and reset.
  input  wire logic       CLK_SYS_I,
  input  wire logic       SYS_RST_I,
  // Host register port.
  input  wire logic [7:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output logic      [7:0] RDATA_O,
  // Path overhead indications from the receive framer.
  input  wire logic       POINTER_LOSS_STATE_I,
  input  wire logic       PATH_ALARM_INDICATION_STATE_I,
  input  wire logic       REMOTE_DEFECT_STATE_I,
  input  wire logic       PARITY_ERROR_I,
  input  wire logic       BLOCK_ERROR_I,
  input  wire logic       LABEL_VALID_I,
  input  wire logic [7:0] LABEL_I,
  // Interrupt.
  output logic            INTERRUPT_OUT_N_O
);

  // The snapshot timer must be wide enough for the delay.
  initial begin
    if (SNAP_DELAY < 1 || SNAP_DELAY >= (1 << SNAP_CNT_W)) begin
      $error("SNAP_DELAY out of range");
    end
  end

  host_req_t req;
  path_ind_t ind;
  state_t    st;
  state_t    next_st;

  // Group the ports into the carrier structs.
  assign req = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};
  assign ind = '{pointer_loss_state: POINTER_LOSS_STATE_I,
                 path_alarm_indication_state: PATH_ALARM_INDICATION_STATE_I,
                 remote_defect_state: REMOTE_DEFECT_STATE_I,
                 parity_error: PARITY_ERROR_I,
                 block_error: BLOCK_ERROR_I,
                 label_valid: LABEL_VALID_I,
                 label: LABEL_I};

  // A write to any of these offsets starts a counter snapshot.
  function automatic logic is_snap_trigger(input logic [7:0] a);
    is_snap_trigger = (a == ADDR_COUNT_LOW) || (a == ADDR_COUNT_HIGH) ||
                      (a == ADDR_GLOBAL);
  endfunction

  logic [7:0] events;
  logic       label_change;

  // Next state of the whole block.
  always_comb begin
    next_st = st;
    label_change = 1'b0;
    // Count mismatching labels; the third in a row is a change, which
    // filters single corrupted bytes from raising the flag.
    if (ind.label_valid) begin
      if (ind.label == LABEL_EXPECTED) begin
        next_st.mismatch_run = 2'h0;
      end else if (st.mismatch_run != LABEL_MISMATCHES) begin
        next_st.mismatch_run = st.mismatch_run + 2'h1;
        if (st.mismatch_run + 2'h1 == LABEL_MISMATCHES) begin
          label_change = 1'b1; // R11
        end
      end
      // Keep the first differing label; the register never goes back.
      if (ind.label != LABEL_EXPECTED &&
          st.signal_label_byte == LABEL_EXPECTED) begin
        next_st.signal_label_byte = ind.label; // R13
      end
    end
    // Event vector in flag layout.
    events = 8'h00;
    events[BIT_LABEL] = label_change; // R4
    events[BIT_POINTER] = ind.pointer_loss_state ^ st.prev_pointer; // R5
    events[BIT_ALARM_IND] = ind.path_alarm_indication_state ^
                            st.prev_alarm; // R6
    events[BIT_REMOTE] = ind.remote_defect_state ^ st.prev_remote; // R7
    events[BIT_PARITY] = ind.parity_error; // R8
    events[BIT_BLOCK] = ind.block_error; // R9
    next_st.prev_pointer = ind.pointer_loss_state;
    next_st.prev_alarm = ind.path_alarm_indication_state;
    next_st.prev_remote = ind.remote_defect_state;
    // A read clears the flags, but an event in that cycle is kept.
    if (req.rd && req.addr == ADDR_IRQ_FLAGS) begin
      next_st.flags = events; // R3
    end else begin
      next_st.flags = st.flags | events;
    end
    // Error counter saturates so an overflowed count is obvious.
    if (ind.parity_error && st.parity_error_count != 16'hffff) begin
      next_st.parity_error_count = st.parity_error_count + 16'h0001;
    end
    // Snapshot timer; a new trigger restarts the delay.
    if (req.wr && is_snap_trigger(req.addr)) begin
      next_st.snap_busy = 1'b1; // R14
      next_st.snap_timer = SNAP_CNT_W'(SNAP_DELAY - 1);
    end else if (st.snap_busy) begin
      if (st.snap_timer == '0) begin
        next_st.snap_busy = 1'b0;
        // The error of this cycle goes to the new round only, so that no
        // error is counted twice across a snapshot.
        next_st.snapshot = st.parity_error_count; // R14
        next_st.parity_error_count = {15'h0000, ind.parity_error};
      end else begin
        next_st.snap_timer = st.snap_timer - 1'b1;
      end
    end
    // Enable register write.
    if (req.wr && req.addr == ADDR_IRQ_ENABLES) begin
      next_st.enables = req.wdata & IRQ_BITS_MASK;
    end
    // Read data for the cycle after the read strobe.
    next_st.rdata = 8'h00;
    if (req.rd) begin
      case (req.addr)
        ADDR_ALARM_STATUS: begin
          next_st.rdata[BIT_POINTER] = ind.pointer_loss_state; // R2
          next_st.rdata[BIT_ALARM_IND] =
            ind.path_alarm_indication_state; // R2
          next_st.rdata[BIT_REMOTE] = ind.remote_defect_state; // R1
        end
        ADDR_IRQ_FLAGS: next_st.rdata = st.flags;
        ADDR_IRQ_ENABLES: next_st.rdata = st.enables;
        ADDR_LABEL: next_st.rdata = st.signal_label_byte;
        ADDR_COUNT_LOW: next_st.rdata = st.snapshot[7:0]; // R15
        ADDR_COUNT_HIGH: next_st.rdata = st.snapshot[15:8]; // R15
        default: next_st.rdata = 8'h00;
      endcase
    end
    // Low level interrupt while any enabled flag is set.
    next_st.interrupt_out_n =
      ~|(next_st.flags & next_st.enables); // R10 R12
  end

  // State register.
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      st <= '0;
      st.signal_label_byte <= LABEL_EXPECTED;
      st.enables <= ENABLE_RESET; // R10
      st.interrupt_out_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign RDATA_O = st.rdata;
  assign INTERRUPT_OUT_N_O = st.interrupt_out_n;

  // Checks on the flags, interrupt, label register, alarm status read and snapshot.
  AST_READ_CLEARS: assert property (@(posedge CLK_SYS_I) disable iff
    (SYS_RST_I) (RD_I && ADDR_I == ADDR_IRQ_FLAGS && !PARITY_ERROR_I)
    |=> !st.flags[BIT_PARITY]) else $error("flag not cleared"); // R3
  AST_POINTER_FLAG: assert property (@(posedge CLK_SYS_I) disable iff
    (SYS_RST_I) $changed(POINTER_LOSS_STATE_I)
    && $past(!SYS_RST_I) |=> st.flags[BIT_POINTER])
    else $error("pointer flag missing"); // R5
  AST_ALARM_FLAG: assert property (@(posedge CLK_SYS_I) disable iff
    (SYS_RST_I) $past(!SYS_RST_I) && $changed(PATH_ALARM_INDICATION_STATE_I)
    |=> st.flags[BIT_ALARM_IND]) else $error("alarm flag missing"); // R6
  AST_REMOTE_FLAG: assert property (@(posedge CLK_SYS_I) disable iff
    (SYS_RST_I) $past(!SYS_RST_I) && $changed(REMOTE_DEFECT_STATE_I)
    |=> st.flags[BIT_REMOTE]) else $error("remote flag missing"); // R7
  AST_PARITY_FLAG: assert property (@(posedge CLK_SYS_I) disable iff
    (SYS_RST_I) PARITY_ERROR_I |=> st.flags[BIT_PARITY])
    else $error("parity flag missing"); // R8
  AST_BLOCK_FLAG: assert property (@(posedge CLK_SYS_I) disable iff
    (SYS_RST_I) BLOCK_ERROR_I |=> st.flags[BIT_BLOCK])
    else $error("block flag missing"); // R9
  AST_IRQ_LEVEL: assert property (@(posedge CLK_SYS_I) disable iff
    (SYS_RST_I) INTERRUPT_OUT_N_O == !(|(st.flags & st.enables)))
    else $error("interrupt level wrong"); // R10
  AST_LABEL_HOLD: assert property (@(posedge CLK_SYS_I) disable iff
    (SYS_RST_I) st.signal_label_byte != LABEL_EXPECTED
    |=> $stable(st.signal_label_byte)) else $error("label moved"); // R13
  AST_REMOTE_READ: assert property (@(posedge CLK_SYS_I) disable iff
    (SYS_RST_I) RD_I && ADDR_I == ADDR_ALARM_STATUS
    |=> RDATA_O[BIT_REMOTE] == $past(REMOTE_DEFECT_STATE_I))
    else $error("remote bit wrong"); // R1
  AST_SNAP_TIME: assert property (@(posedge CLK_SYS_I) disable iff
    (SYS_RST_I) WR_I && is_snap_trigger(ADDR_I) |=> st.snap_busy [*8])
    else $error("snapshot too early"); // R14

  // Main scenarios.
  COV_IRQ: cover property (@(posedge CLK_SYS_I) !INTERRUPT_OUT_N_O);
  COV_LABEL: cover property (@(posedge CLK_SYS_I) st.flags[BIT_LABEL]);
  COV_SNAP: cover property (@(posedge CLK_SYS_I)
    $fell(st.snap_busy) && st.snapshot != 16'h0000);
  COV_CLEAR: cover property (@(posedge CLK_SYS_I)
    RD_I && ADDR_I == ADDR_IRQ_FLAGS && st.flags != 8'h00);

endmodule

// >>> verification/rpoh_host.sv
// Host processor model that drives the register port of the block.
`timescale 1ns/10ps
module rpoh_host (
  // Clock.
  input  wire logic       clk_i,
  // Register port toward the block.
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            wr_o,
  output logic            rd_o,
  input  wire logic [7:0] rdata_i
);
  // Idle bus from time zero, so that no strobe is ever unknown.
  initial begin
    addr_o  = 8'h00;
    wdata_o = 8'h00;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  // One-cycle write strobe beside the address and the data.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken
  // just after that edge. Reading the flags is how this host clears them.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    #1 d = rdata_i;
  endtask
endmodule

// >>> verification/testbench.sv
// Self-checking testbench for the path overhead status registers.
`timescale 1ns/10ps
module testbench;
  import rpoh_pkg::*;
  // A short snapshot delay keeps the run brief.
  localparam int SNAP = 9;
  logic       clk, rst, ptr, ais, rem, par, blk, lv, wr, rd, int_n;
  logic [7:0] addr, wdata, rdata, lab, v;
  int         err_total = 0;
  int         n_tests = 0;

  // Clock at 40 MHz.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  rpoh_host u_host (.clk_i(clk), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd), .rdata_i(rdata));

  rx_path_overhead_status_regs #(.SNAP_DELAY(SNAP)) u_dut (
    .CLK_SYS_I(clk), .SYS_RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .POINTER_LOSS_STATE_I(ptr),
    .PATH_ALARM_INDICATION_STATE_I(ais), .REMOTE_DEFECT_STATE_I(rem),
    .PARITY_ERROR_I(par), .BLOCK_ERROR_I(blk), .LABEL_VALID_I(lv),
    .LABEL_I(lab), .INTERRUPT_OUT_N_O(int_n));

  // Compare one value and report a mismatch at once.
  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  // Read a register through the host and compare it.
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    u_host.rd(a, v);
    chk($sformatf("register %h", a), e, v);
  endtask

  // Sample the interrupt line once its registered level has settled.
  task automatic ichk(input logic e);
    repeat (2) @(posedge clk);
    #1 chk("interrupt", {7'h00, e}, {7'h00, int_n});
  endtask

  // One-cycle event pulses from the framer side.
  task automatic pulse(input logic p, b, l, input logic [7:0] x);
    @(posedge clk);
    par <= p;
    blk <= b;
    lv  <= l;
    lab <= x;
    @(posedge clk);
    {par, blk, lv} <= 3'b000;
  endtask

  // Print the counts and the verdict, then stop.
  task automatic final_report;
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Watchdog well beyond the roughly 125 cycles the tests need.
  initial begin
    #200000;
    err_total++;
    final_report();
  end

  // Main sequence.
  initial begin
    {rst, ptr, ais, rem, par, blk, lv} = 7'h40;
    lab = LABEL_EXPECTED;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rchk(ADDR_IRQ_ENABLES, ENABLE_RESET);
    rchk(ADDR_COUNT_LOW, 8'h00);
    rchk(ADDR_COUNT_HIGH, 8'h00);
    rchk(ADDR_LABEL, LABEL_EXPECTED);
    rchk(8'h3f, 8'h00);
    rchk(ADDR_IRQ_FLAGS, 8'h00);
    // Alarm levels rise together, then remote and pointer fall one at a time.
    @(posedge clk);
    {ptr, ais, rem} <= 3'b111;
    rchk(ADDR_ALARM_STATUS, 8'h2c);
    rchk(ADDR_IRQ_FLAGS, 8'h2c);
    rchk(ADDR_IRQ_FLAGS, 8'h00);
    rem <= 1'b0;
    rchk(ADDR_IRQ_FLAGS, 8'h04);
    ptr <= 1'b0;
    rchk(ADDR_IRQ_FLAGS, 8'h20);
    pulse(1'b1, 1'b1, 1'b0, 8'h00);
    rchk(ADDR_IRQ_FLAGS, 8'h03);
    // Enables gate the interrupt; bit 6 does not exist.
    u_host.wr(ADDR_IRQ_ENABLES, 8'hff);
    rchk(ADDR_IRQ_ENABLES, IRQ_BITS_MASK);
    ichk(1'b1);
    u_host.wr(ADDR_IRQ_ENABLES, 8'h01);
    pulse(1'b1, 1'b0, 1'b0, 8'h00);
    ichk(1'b1);
    pulse(1'b0, 1'b1, 1'b0, 8'h00);
    ichk(1'b0);
    rchk(ADDR_IRQ_FLAGS, 8'h03);
    ichk(1'b1);
    // Two foreign labels are not enough, the third is.
    u_host.wr(ADDR_IRQ_ENABLES, 8'h80);
    pulse(1'b0, 1'b0, 1'b1, 8'h22);
    pulse(1'b0, 1'b0, 1'b1, 8'h23);
    ichk(1'b1);
    pulse(1'b0, 1'b0, 1'b1, 8'h24);
    ichk(1'b0);
    rchk(ADDR_IRQ_FLAGS, 8'h80);
    rchk(ADDR_LABEL, 8'h22);
    // Snapshot appears only after the delay, and the counter restarts.
    repeat (5) pulse(1'b1, 1'b0, 1'b0, 8'h00);
    u_host.wr(ADDR_GLOBAL, 8'h00);
    rchk(ADDR_COUNT_LOW, 8'h00);
    repeat (SNAP) @(posedge clk);
    // Two earlier parity pulses plus these five since reset.
    rchk(ADDR_COUNT_LOW, 8'h07);
    rchk(ADDR_COUNT_HIGH, 8'h00);
    u_host.wr(ADDR_COUNT_HIGH, 8'h00);
    repeat (SNAP + 2) @(posedge clk);
    rchk(ADDR_COUNT_LOW, 8'h00);
    final_report();
  end
endmodule
